// ---- uart_defines.svh ----
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH

// ==========================================================
// Register select codes (shared by reads and writes)
`define REG_SEL_DATA 2'h0
`define REG_SEL_FORMAT 2'h1
`define REG_SEL_MODEM 2'h2
`define REG_SEL_RATE 2'h3

// ==========================================================
// format_ctl_reg fields
`define FMT_LEN_LSB 0
`define FMT_LEN_MSB 1
`define FMT_TWO_STOP 2
`define FMT_PAR_EN 3
`define FMT_PAR_EVEN 4

// ==========================================================
// rate_select_reg fields
`define RATE_PRE_LSB 0
`define RATE_PRE_MSB 1
`define RATE_DIV_LSB 2
`define RATE_DIV_MSB 6
`define RATE_CO_SEL 7
`define RATE_NUM_DIVISORS 5'h12

// ==========================================================
// modem_ctl_reg fields and reset value
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_MODE_LSB 2
`define MCR_MODE_MSB 3
`define MCR_RX_EN 4
`define MCR_IRQ_EN 5
`define MCR_MODEM_IRQ_EN 6
`define MCR_RESET 8'h00

// ==========================================================
// line_status_reg fields and reset value
`define LSR_PE 0
`define LSR_FE 1
`define LSR_OE 2
`define LSR_BRK 3
`define LSR_MODEM 4
`define LSR_TC 5
`define LSR_TX_HOLDING_EMPTY 6
`define LSR_DR 7
`define LSR_RESET 8'h60

// ==========================================================
// Modem status fields
`define MSR_CTS 0
`define MSR_DSR 1

// ==========================================================
// Timing
`define TICKS_PER_BIT 5'h10
`define TICK_LAST 4'hf
`define TICK_MID 4'h7
`define RESET_HOLD_CYCLES 2

`endif

// ---- uart_pkg.sv ----
package uart_pkg;

	// ==========================================================
	// Operating modes of modem_ctl_reg
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_BREAK = 2'b01,
		MODE_ECHO = 2'b10,
		MODE_LOOP = 2'b11
	} op_mode_t;

	// ==========================================================
	// Transmit and receive sequencer states
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP = 3'b100
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} rx_state_t;

	// ==========================================================
	// Received character with its status
	typedef struct packed {
		logic brk;
		logic fe;
		logic pe;
		logic [7:0] data;
	} rx_word_t;

endpackage : uart_pkg

// ---- two_entry_buffer.sv ----
module two_entry_buffer #(
	parameter int WIDTH = 11
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	logic [WIDTH-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic pop;

	// Handshakes
	assign in_ready_o = (count_reg != 2'h2);
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end

endmodule : two_entry_buffer

// ---- uart_core.sv ----
// Contract
// - Read with select drives chosen register
// - Strobes act only under chip select
// - Data bus driven only during reads
// - Short characters: upper bits ignored, zero
// - Bit zero is first serial bit
// - Serial out idles at mark
// - CTS false blocks start, finishes character
// - CTS ignored in loop mode
// - CTS mirrored, change may interrupt
// - DSR mirrored, change may interrupt only
// - DTR follows its control bit
// - RTS follows its control bit
// - Aux clock selects oscillator or generator
// - Holding-empty set on transfer, cleared write
// - Data ready set on load, cleared read
// - Serial in ignored in loop, reset
// - Master enable gates interrupt, modem separately
// - Reset clears generator and counters
// - Reset loads status 60h (holding empty, complete), clears modem control
// - Reset keeps rate and format registers
// - Idle after reset until programmed
// - Generator gives 72 rates at 16x
`include "uart_defines.svh"

module uart_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic chip_select_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [1:0] reg_sel_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	input wire logic serial_in_i,
	output logic serial_out_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic aux_clock_out_o,
	output logic tx_holding_empty_o,
	output logic rx_data_ready_o,
	output logic irq_out_o
);

	localparam int RXW = $bits(uart_pkg::rx_word_t);

	// ==========================================================
	// Helper functions
	function automatic logic [2:0] prescale_div(input logic [1:0] sel);
		case (sel)
			2'h0: prescale_div = 3'h1;
			2'h1: prescale_div = 3'h3;
			2'h2: prescale_div = 3'h4;
			default: prescale_div = 3'h5;
		endcase
	endfunction : prescale_div

	// Divisor in thirds of a prescaler tick
	function automatic logic [11:0] divisor_thirds(input logic [4:0] sel);
		case (sel)
			5'h00: divisor_thirds = 12'h003;
			5'h01: divisor_thirds = 12'h006;
			5'h02: divisor_thirds = 12'h00c;
			5'h03: divisor_thirds = 12'h010;
			5'h04: divisor_thirds = 12'h018;
			5'h05: divisor_thirds = 12'h020;
			5'h06: divisor_thirds = 12'h030;
			5'h07: divisor_thirds = 12'h03a;
			5'h08: divisor_thirds = 12'h042;
			5'h09: divisor_thirds = 12'h060;
			5'h0a: divisor_thirds = 12'h0c0;
			5'h0b: divisor_thirds = 12'h180;
			5'h0c: divisor_thirds = 12'h240;
			5'h0d: divisor_thirds = 12'h300;
			5'h0e: divisor_thirds = 12'h360;
			5'h0f: divisor_thirds = 12'h420;
			5'h10: divisor_thirds = 12'h600;
			default: divisor_thirds = 12'h900;
		endcase
	endfunction : divisor_thirds

	function automatic logic [7:0] char_mask(input logic [1:0] len);
		char_mask = 8'hff >> (2'h3 - len);
	endfunction : char_mask

	// ==========================================================
	// Configuration and control registers
	logic [7:0] format_ctl_reg;
	logic [7:0] rate_select_reg;
	logic [7:0] modem_ctl_reg;
	logic rate_valid_reg;
	uart_pkg::op_mode_t mode;
	logic loop_mode;
	logic echo_mode;
	logic break_mode;
	logic [7:0] mask;
	logic [2:0] last_bit;

	assign mode = uart_pkg::op_mode_t'(modem_ctl_reg[`MCR_MODE_MSB:`MCR_MODE_LSB]);
	assign loop_mode = (mode == uart_pkg::MODE_LOOP);
	assign echo_mode = (mode == uart_pkg::MODE_ECHO);
	assign break_mode = (mode == uart_pkg::MODE_BREAK);
	assign mask = char_mask(format_ctl_reg[`FMT_LEN_MSB:`FMT_LEN_LSB]);
	assign last_bit = {1'b0, format_ctl_reg[`FMT_LEN_MSB:`FMT_LEN_LSB]} + 3'h4;

	// ==========================================================
	// Host strobes, sampled on the oscillator clock
	logic wr_act;
	logic rd_act;
	logic wr_prev_reg;
	logic rd_prev_reg;
	logic wr_start;
	logic rd_start;

	assign wr_act = ~wr_n_i & ~chip_select_n_i;
	assign rd_act = ~rd_n_i & ~chip_select_n_i;
	assign wr_start = wr_act & ~wr_prev_reg;
	assign rd_start = rd_act & ~rd_prev_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_prev_reg <= 1'b0;
			rd_prev_reg <= 1'b0;
		end else begin
			wr_prev_reg <= wr_act;
			rd_prev_reg <= rd_act;
		end
	end

	// Format and rate registers survive reset
	always_ff @(posedge clk_i) begin
		if (wr_start && reg_sel_i == `REG_SEL_FORMAT) begin
			format_ctl_reg <= data_i;
		end
		if (wr_start && reg_sel_i == `REG_SEL_RATE) begin
			rate_select_reg <= data_i;
		end
	end

	// Modem control, cleared by reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			modem_ctl_reg <= `MCR_RESET;
			rate_valid_reg <= 1'b0;
		end else begin
			if (wr_start && reg_sel_i == `REG_SEL_MODEM) begin
				modem_ctl_reg <= data_i;
			end
			if (wr_start && reg_sel_i == `REG_SEL_RATE) begin
				rate_valid_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Rate generator: prescaler then fractional divisor
	logic [2:0] pre_cnt_reg;
	logic pre_tick;
	logic [11:0] acc_reg;
	logic [11:0] acc_sum;
	logic [11:0] div3;
	logic baud16_tick_reg;
	logic gen_level_reg;

	assign pre_tick = rate_valid_reg && (pre_cnt_reg == prescale_div(rate_select_reg[`RATE_PRE_MSB:`RATE_PRE_LSB]) - 3'h1);
	assign div3 = divisor_thirds(rate_select_reg[`RATE_DIV_MSB:`RATE_DIV_LSB]);
	assign acc_sum = acc_reg + 12'h003;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt_reg <= 3'h0;
			acc_reg <= 12'h000;
			baud16_tick_reg <= 1'b0;
			gen_level_reg <= 1'b0;
		end else begin
			baud16_tick_reg <= 1'b0;
			if (!rate_valid_reg || pre_tick) begin
				pre_cnt_reg <= 3'h0;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 3'h1;
			end
			if (pre_tick) begin
				if (acc_sum >= div3) begin
					acc_reg <= acc_sum - div3;
					baud16_tick_reg <= 1'b1;
				end else begin
					acc_reg <= acc_sum;
				end
			end
			gen_level_reg <= ({acc_reg[10:0], 1'b0} < div3);
		end
	end

	// Clock output selection
	logic osc_half_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_half_reg <= 1'b0;
			aux_clock_out_o <= 1'b0;
		end else begin
			osc_half_reg <= ~osc_half_reg;
			if (rate_valid_reg && rate_select_reg[`RATE_CO_SEL]) begin
				aux_clock_out_o <= gen_level_reg;
			end else begin
				aux_clock_out_o <= osc_half_reg;
			end
		end
	end

	// ==========================================================
	// Transmitter
	uart_pkg::tx_state_t tx_state_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] tx_shift_reg;
	logic [2:0] tx_bit_reg;
	logic [3:0] tx_tick_reg;
	logic tx_stop2_reg;
	logic tx_par_reg;
	logic tx_line_reg;
	logic tx_holding_empty_reg;
	logic tc_reg;
	logic tx_go;
	logic tx_bit_end;

	assign tx_go = tx_state_reg == uart_pkg::TX_IDLE && !tx_holding_empty_reg && baud16_tick_reg && !echo_mode
		&& (loop_mode || !cts_n_i);
	assign tx_bit_end = baud16_tick_reg && tx_tick_reg == `TICK_LAST;

	always_ff @(posedge clk_i) begin
		if (wr_start && reg_sel_i == `REG_SEL_DATA) begin
			tx_hold_reg <= data_i & mask;
		end
	end

	// Sequencer; a started character always runs to its stop bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_state_reg <= uart_pkg::TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_bit_reg <= 3'h0;
			tx_tick_reg <= 4'h0;
			tx_stop2_reg <= 1'b0;
			tx_par_reg <= 1'b0;
			tx_line_reg <= 1'b1;
		end else begin
			if (tx_state_reg != uart_pkg::TX_IDLE && baud16_tick_reg) begin
				tx_tick_reg <= tx_tick_reg + 4'h1;
			end
			case (tx_state_reg)
				uart_pkg::TX_IDLE: begin
					tx_line_reg <= 1'b1;
					if (tx_go) begin
						tx_shift_reg <= tx_hold_reg;
						tx_par_reg <= ^tx_hold_reg ^ ~format_ctl_reg[`FMT_PAR_EVEN];
						tx_bit_reg <= 3'h0;
						tx_tick_reg <= 4'h0;
						tx_line_reg <= 1'b0;
						tx_state_reg <= uart_pkg::TX_START;
					end
				end
				uart_pkg::TX_START: begin
					if (tx_bit_end) begin
						tx_line_reg <= tx_shift_reg[0] & ~break_mode;
						tx_state_reg <= uart_pkg::TX_DATA;
					end
				end
				uart_pkg::TX_DATA: begin
					if (tx_bit_end) begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg != last_bit) begin
							tx_line_reg <= tx_shift_reg[1] & ~break_mode;
						end else if (format_ctl_reg[`FMT_PAR_EN]) begin
							tx_line_reg <= tx_par_reg & ~break_mode;
							tx_state_reg <= uart_pkg::TX_PARITY;
						end else begin
							tx_line_reg <= ~break_mode;
							tx_stop2_reg <= format_ctl_reg[`FMT_TWO_STOP];
							tx_state_reg <= uart_pkg::TX_STOP;
						end
					end
				end
				uart_pkg::TX_PARITY: begin
					if (tx_bit_end) begin
						tx_line_reg <= ~break_mode;
						tx_stop2_reg <= format_ctl_reg[`FMT_TWO_STOP];
						tx_state_reg <= uart_pkg::TX_STOP;
					end
				end
				uart_pkg::TX_STOP: begin
					if (tx_bit_end) begin
						tx_stop2_reg <= 1'b0;
						if (!tx_stop2_reg) begin
							tx_line_reg <= 1'b1;
							tx_state_reg <= uart_pkg::TX_IDLE;
						end
					end
				end
				default: begin
					tx_state_reg <= uart_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// Holding-empty and transmission-complete flags
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_holding_empty_reg <= 1'b1;
			tc_reg <= 1'b1;
		end else begin
			if (wr_start && reg_sel_i == `REG_SEL_DATA) begin
				tx_holding_empty_reg <= 1'b0;
				tc_reg <= 1'b0;
			end else begin
				if (tx_go) begin
					tx_holding_empty_reg <= 1'b1;
				end
				if (tx_state_reg == uart_pkg::TX_STOP && tx_bit_end && !tx_stop2_reg && tx_holding_empty_reg) begin
					tc_reg <= 1'b1;
				end
			end
		end
	end

	// Line output: mark in loop, repeat input in echo
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_out_o <= 1'b1;
		end else if (loop_mode) begin
			serial_out_o <= 1'b1;
		end else if (echo_mode) begin
			serial_out_o <= serial_in_i;
		end else begin
			serial_out_o <= tx_line_reg;
		end
	end

	// ==========================================================
	// Receiver
	uart_pkg::rx_state_t rx_state_reg;
	logic [7:0] rx_shift_reg;
	logic [2:0] rx_bit_reg;
	logic [3:0] rx_tick_reg;
	logic rx_stop2_reg;
	logic rx_par_reg;
	logic rx_fe_reg;
	logic rx_in;
	logic rx_sample;
	logic rx_push;
	logic rx_ready;
	uart_pkg::rx_word_t rx_word;

	assign rx_in = !modem_ctl_reg[`MCR_RX_EN] ? 1'b1 : (loop_mode ? tx_line_reg : serial_in_i);
	assign rx_sample = baud16_tick_reg && rx_tick_reg == `TICK_LAST;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_state_reg <= uart_pkg::RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_bit_reg <= 3'h0;
			rx_tick_reg <= 4'h0;
			rx_stop2_reg <= 1'b0;
			rx_par_reg <= 1'b0;
			rx_fe_reg <= 1'b0;
			rx_push <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			if (rx_state_reg != uart_pkg::RX_IDLE && baud16_tick_reg) begin
				rx_tick_reg <= rx_tick_reg + 4'h1;
			end
			case (rx_state_reg)
				uart_pkg::RX_IDLE: begin
					if (baud16_tick_reg && !rx_in) begin
						rx_tick_reg <= 4'h0;
						rx_state_reg <= uart_pkg::RX_START;
					end
				end
				uart_pkg::RX_START: begin
					if (baud16_tick_reg && rx_tick_reg == `TICK_MID) begin
						rx_tick_reg <= 4'h0;
						rx_bit_reg <= 3'h0;
						rx_shift_reg <= 8'h00;
						rx_fe_reg <= 1'b0;
						rx_state_reg <= rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
					end
				end
				uart_pkg::RX_DATA: begin
					if (rx_sample) begin
						rx_shift_reg[rx_bit_reg] <= rx_in;
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == last_bit) begin
							rx_stop2_reg <= format_ctl_reg[`FMT_TWO_STOP];
							rx_state_reg <= format_ctl_reg[`FMT_PAR_EN] ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
						end
					end
				end
				uart_pkg::RX_PARITY: begin
					if (rx_sample) begin
						rx_par_reg <= rx_in ^ ^rx_shift_reg ^ ~format_ctl_reg[`FMT_PAR_EVEN];
						rx_state_reg <= uart_pkg::RX_STOP;
					end
				end
				uart_pkg::RX_STOP: begin
					if (rx_sample) begin
						rx_stop2_reg <= 1'b0;
						if (!rx_in) begin
							rx_fe_reg <= 1'b1;
						end
						if (!rx_stop2_reg) begin
							rx_push <= 1'b1;
							rx_state_reg <= uart_pkg::RX_IDLE;
						end
					end
				end
				default: begin
					rx_state_reg <= uart_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Assembled word; parity error only when parity is enabled
	assign rx_word.data = rx_shift_reg & mask;
	assign rx_word.pe = format_ctl_reg[`FMT_PAR_EN] & rx_par_reg;
	assign rx_word.fe = rx_fe_reg;
	assign rx_word.brk = rx_fe_reg && rx_shift_reg == 8'h00 && !(format_ctl_reg[`FMT_PAR_EN] & rx_par_reg ^ rx_par_reg);

	// ==========================================================
	// Buffer between receiver and host holding register
	logic [RXW-1:0] buf_out;
	logic buf_valid;
	logic dr_reg;
	uart_pkg::rx_word_t buf_word;

	two_entry_buffer #(
		.WIDTH(RXW)
	) rx_buffer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(rx_push),
		.in_ready_o(rx_ready),
		.in_data_i(rx_word),
		.out_valid_o(buf_valid),
		.out_ready_i(!dr_reg),
		.out_data_o(buf_out)
	);

	assign buf_word = uart_pkg::rx_word_t'(buf_out);

	// ==========================================================
	// Holding register and status flags
	logic [7:0] rx_holding_reg;
	logic pe_reg;
	logic fe_reg;
	logic oe_reg;
	logic brk_reg;
	logic modem_flag_reg;
	logic modem_seen_reg;
	logic cts_prev_reg;
	logic dsr_prev_reg;
	logic modem_change;
	logic rd_status;

	assign modem_change = modem_seen_reg && (cts_prev_reg != cts_n_i || dsr_prev_reg != dsr_n_i);
	assign rd_status = rd_start && reg_sel_i == `REG_SEL_FORMAT;

	always_ff @(posedge clk_i) begin
		if (buf_valid && !dr_reg) begin
			rx_holding_reg <= buf_word.data;
		end
	end

	// Events win over the clearing read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dr_reg <= 1'b0;
			pe_reg <= 1'b0;
			fe_reg <= 1'b0;
			oe_reg <= 1'b0;
			brk_reg <= 1'b0;
			modem_flag_reg <= 1'b0;
			modem_seen_reg <= 1'b0;
			cts_prev_reg <= 1'b1;
			dsr_prev_reg <= 1'b1;
		end else begin
			modem_seen_reg <= 1'b1;
			cts_prev_reg <= cts_n_i;
			dsr_prev_reg <= dsr_n_i;
			if (buf_valid && !dr_reg) begin
				dr_reg <= 1'b1;
				pe_reg <= buf_word.pe;
				fe_reg <= buf_word.fe;
				brk_reg <= buf_word.brk;
			end else if (rd_start && reg_sel_i == `REG_SEL_DATA) begin
				dr_reg <= 1'b0;
			end
			if (rx_push && !rx_ready) begin
				oe_reg <= 1'b1;
			end else if (rd_status) begin
				oe_reg <= 1'b0;
			end
			if (modem_change) begin
				modem_flag_reg <= 1'b1;
			end else if (rd_start && reg_sel_i == `REG_SEL_RATE) begin
				modem_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read path and bus drive
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (reg_sel_i)
			`REG_SEL_DATA: rd_mux = rx_holding_reg & mask;
			`REG_SEL_FORMAT: begin
				rd_mux[`LSR_PE] = pe_reg;
				rd_mux[`LSR_FE] = fe_reg;
				rd_mux[`LSR_OE] = oe_reg;
				rd_mux[`LSR_BRK] = brk_reg;
				rd_mux[`LSR_MODEM] = modem_flag_reg;
				rd_mux[`LSR_TC] = tc_reg;
				rd_mux[`LSR_TX_HOLDING_EMPTY] = tx_holding_empty_reg;
				rd_mux[`LSR_DR] = dr_reg;
			end
			`REG_SEL_MODEM: rd_mux = modem_ctl_reg;
			default: begin
				rd_mux[`MSR_CTS] = ~cts_n_i;
				rd_mux[`MSR_DSR] = ~dsr_n_i;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
		end else begin
			data_oe_o <= rd_act;
			if (rd_start) begin
				data_o <= rd_mux;
			end
		end
	end

	// ==========================================================
	// Pin outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dtr_n_o <= 1'b1;
			rts_n_o <= 1'b1;
			tx_holding_empty_o <= 1'b1;
			rx_data_ready_o <= 1'b0;
			irq_out_o <= 1'b0;
		end else begin
			dtr_n_o <= ~modem_ctl_reg[`MCR_DTR];
			rts_n_o <= ~modem_ctl_reg[`MCR_RTS];
			tx_holding_empty_o <= tx_holding_empty_reg;
			rx_data_ready_o <= dr_reg;
			irq_out_o <= modem_ctl_reg[`MCR_IRQ_EN] & (dr_reg | tc_reg | oe_reg | fe_reg | pe_reg
				| (modem_ctl_reg[`MCR_MODEM_IRQ_EN] & modem_flag_reg));
		end
	end

endmodule : uart_core

// ---- uart_core_asserts.sv ----
module uart_core_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic chip_select_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [1:0] reg_sel_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] data_o,
	input wire logic data_oe_o,
	input wire logic dtr_n_o,
	input wire logic rts_n_o,
	input wire logic tx_holding_empty_o,
	input wire logic rx_data_ready_o,
	input wire logic irq_out_o,
	input wire logic serial_out_o
);
	// ====
	// Strobe decoding
	logic rd_act;
	logic wr_act;
	logic wr_prev_reg;
	assign rd_act = !rd_n_i && !chip_select_n_i;
	assign wr_act = !wr_n_i && !chip_select_n_i;

	// Last write level, to spot strobe starts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_prev_reg <= 1'h0;
		end else begin
			wr_prev_reg <= wr_act;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence read_held;
		rd_act ##1 rd_act;
	endsequence
	sequence mcr_write;
		wr_act && !wr_prev_reg && reg_sel_i == 2'h2;
	endsequence

	// ====
	// Bus and pin checks
	oe_rise_a: assert property ($rose(data_oe_o) |-> $past(rd_act)) else $error("bus driven without read");
	oe_answer_a: assert property (read_held |-> data_oe_o) else $error("read not answered");
	oe_release_a: assert property (!rd_act ##1 !rd_act |-> !data_oe_o) else $error("bus still driven");
	data_hold_a: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o)) else $error("read data moved");
	reset_state_a: assert property (disable iff (1'h0) rst_i |-> dtr_n_o && rts_n_o && tx_holding_empty_o
		&& !rx_data_ready_o && !irq_out_o && serial_out_o && !data_oe_o) else $error("bad reset state");
	empty_fall_a: assert property ($fell(tx_holding_empty_o) |-> $past(wr_act && !wr_prev_reg && reg_sel_i == 2'h0, 2))
		else $error("empty flag fell without write");
	ready_fall_a: assert property ($fell(rx_data_ready_o) |-> $past(rd_act && reg_sel_i == 2'h0, 2))
		else $error("data ready fell without read");
	modem_pins_a: assert property (mcr_write |-> ##2 (dtr_n_o == !$past(data_i[0], 2) && rts_n_o == !$past(data_i[1], 2)))
		else $error("modem pins wrong");
endmodule : uart_core_asserts

bind uart_core uart_core_asserts uart_core_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
	.chip_select_n_i(chip_select_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .reg_sel_i(reg_sel_i), .data_i(data_i),
	.data_o(data_o), .data_oe_o(data_oe_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .irq_out_o(irq_out_o),
	.tx_holding_empty_o(tx_holding_empty_o), .rx_data_ready_o(rx_data_ready_o), .serial_out_o(serial_out_o));

// ---- serial_far_end.sv ----
module serial_far_end (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	output logic serial_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] frame;
	// ====
	// Idles at mark, sends start, data LSB first, stop
	initial serial_o = 1'h1;
	always @(posedge go_i) begin
		frame = {1'h1, byte_i, 1'h0};
		for (int i = 0; i < 10; i++) begin
			serial_o = frame[i];
			repeat (16) @(negedge clk_i);
		end
	end
endmodule : serial_far_end

// ---- uart_core_tb.sv ----
module uart_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst, cs_n, rd_n, wr_n, go, sin, so, oe, dtr_n, rts_n, tx_holding_empty, dr, irq, cts_n, dsr_n, bad, aux;
	logic [1:0] sel;
	logic [7:0] din, dout;
	int err_count, checks, cycles;

	// ====
	// Clock, design and far end
	always #5 clk = ~clk;
	uart_core uart_core_inst (.clk_i(clk), .rst_i(rst), .chip_select_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.reg_sel_i(sel), .data_i(din), .data_o(dout), .data_oe_o(oe), .serial_in_i(sin), .serial_out_o(so),
		.cts_n_i(cts_n), .dsr_n_i(dsr_n), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .aux_clock_out_o(aux),
		.tx_holding_empty_o(tx_holding_empty), .rx_data_ready_o(dr), .irq_out_o(irq));
	serial_far_end serial_far_end_inst (.clk_i(clk), .go_i(go), .byte_i(8'hff), .serial_o(sin));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One bus access, strobe held two cycles
	task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		{cs_n, sel, din, wr_n, rd_n} = {1'h0, s, d, !w, w};
		repeat (2) @(negedge clk);
		q = dout;
		if (!w) chk("bus enable", 8'h1, {7'h0, oe});
		{cs_n, wr_n, rd_n} = 3'h7;
		@(negedge clk);
	endtask : acc
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		logic [7:0] q;
		acc(1'h1, s, d, q);
	endtask : wr
	task automatic rd(input logic [1:0] s, input logic [7:0] exp);
		logic [7:0] q;
		acc(1'h0, s, 8'h0, q);
		chk("read data", exp, q);
	endtask : rd
	// Waits up to n cycles for data ready while the line must stay at mark
	task automatic idle(input int n);
		bad = 1'h0;
		for (int i = 0; i < n && dr !== 1'h1; i++) begin
			@(negedge clk);
			bad |= (so !== 1'h1);
		end
		chk("line at mark", 8'h0, {7'h0, bad});
	endtask : idle

	task automatic t_modem();
		@(negedge clk);
		{sel, din, wr_n} = {2'h2, 8'h03, 1'h0};
		repeat (2) @(negedge clk);
		wr_n = 1'h1;
		rd(2'h2, 8'h00);
		wr(2'h2, 8'h03);
		chk("dtr rts", 8'h0, {6'h0, dtr_n, rts_n});
		rd(2'h2, 8'h03);
		wr(2'h2, 8'h00);
		chk("dtr rts", 8'h3, {6'h0, dtr_n, rts_n});
	endtask : t_modem
	task automatic t_loop();
		wr(2'h1, 8'h03);
		wr(2'h3, 8'h00);
		wr(2'h2, 8'h1c);
		wr(2'h0, 8'ha5);
		idle(400);
		rd(2'h0, 8'ha5);
		chk("data ready", 8'h0, {7'h0, dr});
	endtask : t_loop
	task automatic t_tx();
		wr(2'h2, 8'h10);
		wr(2'h0, 8'h6c);
		idle(100);
		chk("empty", 8'h0, {7'h0, tx_holding_empty});
		cts_n = 1'h0;
		for (int i = 0; i < 100 && so !== 1'h0; i++) @(negedge clk);
		repeat (8) @(negedge clk);
		chk("start bit", 8'h0, {7'h0, so});
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(negedge clk);
			if (i == 2) cts_n = 1'h1;
			chk("tx bit", (i == 8) ? 8'h1 : ((8'h6c >> i) & 8'h1), {7'h0, so});
		end
		chk("empty", 8'h1, {7'h0, tx_holding_empty});
	endtask : t_tx
	task automatic t_short();
		wr(2'h1, 8'h00);
		go = 1'h1;
		idle(400);
		go = 1'h0;
		rd(2'h0, 8'h1f);
	endtask : t_short
	task automatic t_irq();
		logic [7:0] q;
		wr(2'h2, 8'h00);
		dsr_n = 1'h0;
		repeat (3) @(negedge clk);
		chk("irq", 8'h0, {7'h0, irq});
		acc(1'h0, 2'h1, 8'h0, q);
		chk("modem change", 8'h1, {7'h0, q[4]});
		rd(2'h3, 8'h02);
		acc(1'h0, 2'h1, 8'h0, q);
		chk("modem change", 8'h0, {7'h0, q[4]});
		wr(2'h2, 8'h20);
		chk("irq", 8'h1, {7'h0, irq});
	endtask : t_irq
	// Mid-run reset: outputs cleared, format kept
	task automatic t_reset();
		wr(2'h1, 8'h02);
		@(negedge clk);
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		chk("pins", 8'h78, {1'h0, dtr_n, rts_n, so, tx_holding_empty, dr, irq, oe});
		rd(2'h1, 8'h60);
		wr(2'h3, 8'h00);
		wr(2'h2, 8'h1c);
		wr(2'h0, 8'hff);
		idle(400);
		rd(2'h0, 8'h7f);
	endtask : t_reset
	// Clock out: oscillator half rate, then generator at divisor four
	task automatic t_aux();
		logic [7:0] v;
		wr(2'h3, 8'h08);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			v[i] = aux;
		end
		chk("aux clock", ~v, {v[6:0], v[7]});
		wr(2'h3, 8'h88);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			v[i] = aux;
		end
		chk("aux clock", ~v, {v[5:0], v[7:6]});
	endtask : t_aux

	task automatic tally_and_finish();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// Main sequence
	initial begin
		{rst, cs_n, rd_n, wr_n, go, cts_n, dsr_n, sel, din} = {7'h3b, 2'h0, 8'h00};
		#1 rst = 1'h1;
		repeat (8) @(negedge clk);
		rst = 1'h0;
		chk("pins", 8'h78, {1'h0, dtr_n, rts_n, so, tx_holding_empty, dr, irq, oe});
		rd(2'h1, 8'h60);
		t_modem();
		t_loop();
		t_tx();
		t_short();
		t_irq();
		t_reset();
		t_aux();
		tally_and_finish();
	end
endmodule : uart_core_tb
